// *** sppc_defs.svh ***
// What this block does
// - SPI slave: transmit clock pin input, receive follows
// - SPI master: drive transmit clock, receiver uses it
// - No loop-back: receive clock pin direction bit
// - Loop-back, bit clear: receive follows transmit, pin off
// - Loop-back, bit set: receive pin outputs transmit clock
// - Two bits pick generator reference among four
// - Bit 6 shows sample-clock pin as input
// - Bit 5 drives transmit data pin as output
// - Bit 4 shows receive data pin as input
// - Sync polarity bits 3, 2: 0 high
// - Bit 1: transmit sampling edge, 0 rising
// - Bit 0: receive sampling edge, 0 falling
// - Second generator register field layout
// - Pins act as general I/O only in reset
// - Frame period field spaces generated syncs, 1..4096
`ifndef SPPC_DEFS_SVH
`define SPPC_DEFS_SVH

// Register word addresses
`define SPPC_A_PIN 3'h0
`define SPPC_A_SRG 3'h1
`define SPPC_A_SPC 3'h2
`define SPPC_A_STAT 3'h3

// Pin control fields
`define SPPC_PC_TXGPIO 13
`define SPPC_PC_RXGPIO 12
`define SPPC_PC_TXFSDIR 11
`define SPPC_PC_RXFSDIR 10
`define SPPC_PC_TXDIR 9
`define SPPC_PC_RXDIR 8
`define SPPC_PC_REFX 7
`define SPPC_PC_EXTLVL 6
`define SPPC_PC_TXDLVL 5
`define SPPC_PC_RXDLVL 4
`define SPPC_PC_TXFSP 3
`define SPPC_PC_RXFSP 2
`define SPPC_PC_TXCP 1
`define SPPC_PC_RXCP 0
`define SPPC_PC_WMASK 16'h3faf
`define SPPC_PC_RST 16'h0000

// Rate generator control two fields
`define SPPC_SG_RESYNC 15
`define SPPC_SG_EDGE 14
`define SPPC_SG_REF 13
`define SPPC_SG_FSSRC 12
`define SPPC_SG_RST 16'h0000

// Serial port control one fields
`define SPPC_SC_TXRSTN 0
`define SPPC_SC_RXRSTN 1
`define SPPC_SC_LOOP 2
`define SPPC_SC_SPI_LO 3
`define SPPC_SC_SPI_HI 4
`define SPPC_SC_WMASK 16'h001f
`define SPPC_SC_RST 16'h0000

`endif

// *** sppc_pkg.sv ***
package sppc_pkg;

  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } sppc_bus_t;

  // Pin levels arriving at the block
  typedef struct packed {
    logic tx_clk;
    logic rx_clk;
    logic ext_clk;
    logic rx_data;
    logic rx_fs;
  } sppc_pin_in_t;

  // Pin drive values and enables
  typedef struct packed {
    logic tx_clk_o;
    logic tx_clk_oe;
    logic rx_clk_o;
    logic rx_clk_oe;
    logic tx_data_o;
    logic tx_data_oe;
    logic tx_fs_o;
    logic tx_fs_oe;
    logic rx_fs_o;
    logic rx_fs_oe;
  } sppc_pin_out_t;

  // Generator reference, extended bit then mode bit
  typedef enum logic [1:0] {
    SPPC_REF_EXT = 2'h0,
    SPPC_REF_CPU = 2'h1,
    SPPC_REF_RXPIN = 2'h2,
    SPPC_REF_TXPIN = 2'h3
  } sppc_ref_t;

endpackage

// *** sppc_ctl.sv ***
`timescale 1ns/1ns
`include "sppc_defs.svh"
module sppc_ctl #(
  parameter int FRAME_PERIOD_W = 12,
  parameter int FSCNT_W = 8
) (
  // Clocks and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic link_clk_in,
  // Register port
  input wire sppc_pkg::sppc_bus_t bus_in,
  output logic [15:0] rdata_out,
  // Serial pins
  input wire sppc_pkg::sppc_pin_in_t pins_in,
  output sppc_pkg::sppc_pin_out_t pins_out
);
  import sppc_pkg::*;

  // System domain state
  typedef struct packed {
    logic [15:0] pc; // Pin control store
    logic [15:0] sg; // Rate generator two
    logic [15:0] sc; // Port control one
    sppc_pin_in_t s1; // Pin sync stage 1
    sppc_pin_in_t s2; // Pin sync stage 2
    sppc_pin_in_t s3; // Pin sync stage 3
    sppc_pin_in_t lvl; // Accepted levels
    logic [2:0] tg; // Link toggle sync
    logic tg_seen; // Last counted toggle
    logic [FSCNT_W-1:0] fs_cnt; // Link frame syncs
    logic generator_output_clock; // Generator clock
    logic [FRAME_PERIOD_W-1:0] cnt; // Frame period count
    logic fsg; // Generated sync
    logic rxc_q; // Prior receive clock
    logic txc_q; // Prior transmit clock
    logic rxfs_q; // Prior active sync
    logic rx_bit; // Last sampled bit
    logic [3:0] tx_edges; // Transmit edges
    sppc_pin_out_t pins; // Pin drive
    logic [15:0] rdata; // Read answer
  } sppc_state_t;

  // Link domain state
  typedef struct packed {
    logic rst1; // Reset sync 1
    logic rst2; // Reset sync 2
    logic pol1; // Polarity sync 1
    logic pol2; // Polarity sync 2
    logic fs_q; // Sampled sync pin
    logic act_q; // Prior active sync
    logic tog; // Sync event toggle
  } sppc_link_t;

  sppc_state_t st_r; // System registers
  sppc_state_t st_nxt; // System next
  sppc_link_t lk_r; // Link registers
  sppc_link_t lk_nxt; // Link next

  // Decoded modes
  logic spi; // Clock stop mode on
  logic txg; // Transmit pins general
  logic rxg; // Receive pins general
  logic loop; // Digital loop-back
  logic txc; // Internal transmit clock
  logic rxc; // Internal receive clock
  logic ref_lvl; // Selected reference
  logic rise; // Generator rising edge
  logic rxfs_act; // Receive sync, active high
  logic rxfs_rise; // Receive sync start
  logic resync; // Resync in force
  logic [FRAME_PERIOD_W-1:0] frame_period; // Period field
  logic [4:0] agree; // Sync stages agree
  sppc_ref_t refsel; // Reference choice

  // System next state
  always_comb begin
    st_nxt = st_r;
    // Three stage pin capture
    st_nxt.s1 = pins_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    agree = ~(st_r.s2 ^ st_r.s3);
    st_nxt.lvl = sppc_pin_in_t'((agree & st_r.s3) | (~agree & st_r.lvl));
    // Mode decode
    spi = |st_r.sc[`SPPC_SC_SPI_HI:`SPPC_SC_SPI_LO];
    // Pins turn general only while side is held in reset
    txg = st_r.pc[`SPPC_PC_TXGPIO] & ~st_r.sc[`SPPC_SC_TXRSTN];
    rxg = st_r.pc[`SPPC_PC_RXGPIO] & ~st_r.sc[`SPPC_SC_RXRSTN];
    loop = st_r.sc[`SPPC_SC_LOOP];
    // Transmit clock: generator as master, pin as slave
    txc = st_r.pc[`SPPC_PC_TXDIR] ? st_r.generator_output_clock : st_r.lvl.tx_clk;
    // Receive clock follows transmit in SPI or loop-back
    if (spi || loop) begin
      rxc = txc;
    end else begin
      rxc = st_r.pc[`SPPC_PC_RXDIR] ? st_r.generator_output_clock : st_r.lvl.rx_clk;
    end
    // Generator reference pick
    refsel = sppc_ref_t'({st_r.pc[`SPPC_PC_REFX], st_r.sg[`SPPC_SG_REF]});
    unique case (refsel)
      SPPC_REF_EXT: begin
        ref_lvl = st_r.lvl.ext_clk ^ st_r.sg[`SPPC_SG_EDGE];
      end
      SPPC_REF_CPU: begin
        ref_lvl = ~st_r.generator_output_clock;
      end
      SPPC_REF_RXPIN: begin
        ref_lvl = st_r.lvl.rx_clk;
      end
      SPPC_REF_TXPIN: begin
        ref_lvl = st_r.lvl.tx_clk;
      end
    endcase
    st_nxt.generator_output_clock = ref_lvl;
    rise = ref_lvl & ~st_r.generator_output_clock;
    // Receive sync start, polarity folded out
    rxfs_act = st_r.lvl.rx_fs ^ st_r.pc[`SPPC_PC_RXFSP];
    rxfs_rise = rxfs_act & ~st_r.rxfs_q;
    st_nxt.rxfs_q = rxfs_act;
    // Resync of the frame counter only means something on the external pin
    resync = st_r.sg[`SPPC_SG_RESYNC] & (refsel == SPPC_REF_EXT);
    frame_period = st_r.sg[FRAME_PERIOD_W-1:0];
    // Frame period counter, value n gives n+1 periods
    if (resync && rxfs_rise) begin
      st_nxt.cnt = '0;
      st_nxt.fsg = 1'b1;
    end else if (rise) begin
      if (st_r.cnt >= frame_period) begin
        // Lowered period takes effect at once
        st_nxt.cnt = '0;
        st_nxt.fsg = ~resync;
      end else begin
        st_nxt.cnt = FRAME_PERIOD_W'(st_r.cnt + 1'b1);
        st_nxt.fsg = 1'b0;
      end
    end
    // Receive sample on chosen edge of receive clock
    if ((rxc != st_r.rxc_q) && (rxc == st_r.pc[`SPPC_PC_RXCP])) begin
      st_nxt.rx_bit = st_r.lvl.rx_data;
    end
    st_nxt.rxc_q = rxc;
    // Transmit edge count, taken on transmit clock only
    if ((txc != st_r.txc_q) && (txc != st_r.pc[`SPPC_PC_TXCP])) begin
      st_nxt.tx_edges = st_r.tx_edges + 4'h1;
    end
    st_nxt.txc_q = txc;
    // Link sync events, counted once stages 2 and 3 agree
    st_nxt.tg = {st_r.tg[1:0], lk_r.tog};
    if ((st_r.tg[1] == st_r.tg[2]) && (st_r.tg[2] != st_r.tg_seen)) begin
      st_nxt.tg_seen = st_r.tg[2];
      st_nxt.fs_cnt = FSCNT_W'(st_r.fs_cnt + 1'b1);
    end
    // Transmit clock pin drive
    st_nxt.pins.tx_clk_oe = st_r.pc[`SPPC_PC_TXDIR] & ~txg;
    st_nxt.pins.tx_clk_o = st_r.generator_output_clock;
    // Receive clock pin: off in SPI, loop-back carries txc
    st_nxt.pins.rx_clk_oe = ~spi & ~rxg & st_r.pc[`SPPC_PC_RXDIR];
    st_nxt.pins.rx_clk_o = loop ? txc : st_r.generator_output_clock;
    // Transmit data pin as general output
    st_nxt.pins.tx_data_oe = txg;
    st_nxt.pins.tx_data_o = txg & st_r.pc[`SPPC_PC_TXDLVL];
    // Frame sync pins, polarity applied at the pin
    st_nxt.pins.tx_fs_oe = st_r.pc[`SPPC_PC_TXFSDIR] & ~txg;
    st_nxt.pins.tx_fs_o = (st_r.sg[`SPPC_SG_FSSRC] & st_r.fsg)
                          ^ st_r.pc[`SPPC_PC_TXFSP];
    // Resync turns receive sync pin back into input
    st_nxt.pins.rx_fs_oe = st_r.pc[`SPPC_PC_RXFSDIR]
                           & ~st_r.sg[`SPPC_SG_RESYNC] & ~rxg;
    st_nxt.pins.rx_fs_o = st_r.fsg ^ st_r.pc[`SPPC_PC_RXFSP];
    // Register writes; status bits are not stored
    if (bus_in.wr) begin
      unique case (bus_in.addr)
        `SPPC_A_PIN: begin
          st_nxt.pc = bus_in.wdata & `SPPC_PC_WMASK;
        end
        `SPPC_A_SRG: begin
          st_nxt.sg = bus_in.wdata;
        end
        `SPPC_A_SPC: begin
          st_nxt.sc = bus_in.wdata & `SPPC_SC_WMASK;
        end
        default: begin
          // Unmapped and status writes ignored
        end
      endcase
    end
    // Read answer stands one cycle only
    st_nxt.rdata = 16'h0000;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        `SPPC_A_PIN: begin
          st_nxt.rdata = st_r.pc;
          // Live pin levels only in general input mode
          st_nxt.rdata[`SPPC_PC_EXTLVL] = rxg & st_r.lvl.ext_clk;
          st_nxt.rdata[`SPPC_PC_RXDLVL] = rxg & st_r.lvl.rx_data;
        end
        `SPPC_A_SRG: begin
          st_nxt.rdata = st_r.sg;
        end
        `SPPC_A_SPC: begin
          st_nxt.rdata = st_r.sc;
        end
        `SPPC_A_STAT: begin
          st_nxt.rdata = {st_r.tx_edges, 2'h0, st_r.rx_bit, st_r.fsg,
                          8'(st_r.fs_cnt)};
        end
        default: begin
          // Unmapped reads give zero
        end
      endcase
    end
    // Synchronous reset to documented defaults
    if (!resetn_in) begin
      st_nxt = '0;
      st_nxt.pc = `SPPC_PC_RST;
      st_nxt.sg = `SPPC_SG_RST;
      st_nxt.sc = `SPPC_SC_RST;
    end
  end

  // System registers
  always_ff @(posedge sys_clk_in) begin
    st_r <= st_nxt;
  end

  // Link next state; sync pin is timed to this clock
  always_comb begin
    lk_nxt = lk_r;
    lk_nxt.rst1 = resetn_in;
    lk_nxt.rst2 = lk_r.rst1;
    lk_nxt.pol1 = st_r.pc[`SPPC_PC_RXFSP];
    lk_nxt.pol2 = lk_r.pol1;
    lk_nxt.fs_q = pins_in.rx_fs;
    lk_nxt.act_q = lk_r.fs_q ^ lk_r.pol2;
    // One toggle per frame start
    if ((lk_r.fs_q ^ lk_r.pol2) && !lk_r.act_q) begin
      lk_nxt.tog = ~lk_r.tog;
    end
    // Reset held until link clock has run twice
    if (!lk_r.rst2) begin
      lk_nxt.pol1 = 1'b0;
      lk_nxt.pol2 = 1'b0;
      lk_nxt.fs_q = 1'b0;
      lk_nxt.act_q = 1'b0;
      lk_nxt.tog = 1'b0;
    end
  end

  // Link registers; a stopped link clock freezes them
  always_ff @(posedge link_clk_in) begin
    lk_r <= lk_nxt;
  end

  // Outputs straight from flops
  assign rdata_out = st_r.rdata;
  assign pins_out = st_r.pins;

  // Checks on the system domain
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  property p_spi_slave;
    (spi && !st_r.pc[`SPPC_PC_TXDIR]) |=> (!pins_out.tx_clk_oe && !pins_out.rx_clk_oe);
  endproperty
  a_spi_slave: assert property (p_spi_slave)
    else $error("slave drives a clock pin");

  property p_spi_master;
    (spi && st_r.pc[`SPPC_PC_TXDIR] && !txg)
      |=> (pins_out.tx_clk_oe && pins_out.tx_clk_o == $past(st_r.generator_output_clock));
  endproperty
  a_spi_master: assert property (p_spi_master)
    else $error("master not driving clock");

  property p_rx_dir;
    (!spi && !loop && !rxg) |=> (pins_out.rx_clk_oe == $past(st_r.pc[`SPPC_PC_RXDIR]));
  endproperty
  a_rx_dir: assert property (p_rx_dir)
    else $error("receive clock direction wrong");

  property p_loop_off;
    (loop && !st_r.pc[`SPPC_PC_RXDIR]) |=> !pins_out.rx_clk_oe;
  endproperty
  a_loop_off: assert property (p_loop_off)
    else $error("loop-back pin not released");

  property p_loop_out;
    (!spi && loop && st_r.pc[`SPPC_PC_RXDIR] && !rxg)
      |=> (pins_out.rx_clk_oe && pins_out.rx_clk_o == $past(txc));
  endproperty
  a_loop_out: assert property (p_loop_out)
    else $error("loop-back pin not transmit clock");

  property p_ref_pick;
    (refsel == SPPC_REF_TXPIN) |=> (st_r.generator_output_clock == $past(st_r.lvl.tx_clk));
  endproperty
  a_ref_pick: assert property (p_ref_pick)
    else $error("generator reference wrong");

  property p_ext_stat;
    (bus_in.rd && bus_in.addr == `SPPC_A_PIN)
      |=> (rdata_out[`SPPC_PC_EXTLVL] == $past(rxg & st_r.lvl.ext_clk));
  endproperty
  a_ext_stat: assert property (p_ext_stat)
    else $error("sample clock status wrong");

  property p_dx_out;
    txg |=> (pins_out.tx_data_oe && pins_out.tx_data_o == $past(st_r.pc[`SPPC_PC_TXDLVL]));
  endproperty
  a_dx_out: assert property (p_dx_out)
    else $error("data pin not general output");

  property p_rx_data_pin_level;
    (bus_in.rd && bus_in.addr == `SPPC_A_PIN)
      |=> (rdata_out[`SPPC_PC_RXDLVL] == $past(rxg & st_r.lvl.rx_data));
  endproperty
  a_rx_data_pin_level: assert property (p_rx_data_pin_level)
    else $error("receive data status wrong");

  property p_txfs_pol;
    (st_r.sg[`SPPC_SG_FSSRC] && !st_r.fsg)
      |=> (pins_out.tx_fs_o == $past(st_r.pc[`SPPC_PC_TXFSP]));
  endproperty
  a_txfs_pol: assert property (p_txfs_pol)
    else $error("idle sync level wrong");

  property p_srg_write;
    (bus_in.wr && bus_in.addr == `SPPC_A_SRG) |=> (st_r.sg == $past(bus_in.wdata));
  endproperty
  a_srg_write: assert property (p_srg_write)
    else $error("generator register not stored");

  property p_gpio_gate;
    (st_r.sc[`SPPC_SC_TXRSTN] && st_r.sc[`SPPC_SC_RXRSTN]) |=> !pins_out.tx_data_oe;
  endproperty
  a_gpio_gate: assert property (p_gpio_gate)
    else $error("general output outside reset");

  property p_period_wrap;
    (rise && !resync && st_r.cnt >= frame_period) |=> (st_r.cnt == '0 && st_r.fsg);
  endproperty
  a_period_wrap: assert property (p_period_wrap)
    else $error("frame period wrap wrong");

  property p_rx_edge;
    (rxc != st_r.rxc_q && rxc == st_r.pc[`SPPC_PC_RXCP])
      |=> (st_r.rx_bit == $past(st_r.lvl.rx_data));
  endproperty
  a_rx_edge: assert property (p_rx_edge)
    else $error("receive bit not sampled");

  // Transmit count must move on each selected edge
  property p_tx_edge;
    (txc != st_r.txc_q && txc != st_r.pc[`SPPC_PC_TXCP])
      |=> (st_r.tx_edges == 4'($past(st_r.tx_edges) + 4'h1));
  endproperty
  a_tx_edge: assert property (p_tx_edge)
    else $error("transmit edge not counted");

  // Idle receive sync level follows its polarity bit
  property p_rxfs_pol;
    !st_r.fsg |=> (pins_out.rx_fs_o == $past(st_r.pc[`SPPC_PC_RXFSP]));
  endproperty
  a_rxfs_pol: assert property (p_rxfs_pol)
    else $error("receive sync idle level wrong");

  // Resync hands the receive sync pin back to the far side
  property p_resync_pin;
    st_r.sg[`SPPC_SG_RESYNC] |=> !pins_out.rx_fs_oe;
  endproperty
  a_resync_pin: assert property (p_resync_pin)
    else $error("receive sync pin driven in resync");

  // Main scenarios
  c_frame: cover property (rise && st_r.cnt >= frame_period && !resync);
  c_loop: cover property (loop && pins_out.rx_clk_oe);
  c_link_fs: cover property (st_r.fs_cnt != '0);
  c_gpio: cover property (pins_out.tx_data_oe && pins_out.tx_data_o);
  c_tx_edge: cover property (st_r.tx_edges != 4'h0);

endmodule

// *** sppc_partner.sv ***
`timescale 1ns/1ns
module sppc_partner (
  // Device pin drive
  input wire sppc_pkg::sppc_pin_out_t dev_pins_in,
  // Bench controls: run bits tx, rx, ext source
  input wire logic [2:0] run_in,
  input wire logic ext_level_in,
  input wire logic rxd_level_in,
  input wire logic fs_level_in,
  // Wire levels and link clock
  output sppc_pkg::sppc_pin_in_t wire_out,
  output logic link_clk_out
);
  import sppc_pkg::*;
  // Free oscillator, seen on a pin only while its run bit is set
  logic osc = 1'b0;
  // Frame sync level as put on the wire
  logic fs_r = 1'b0;
  // Oscillator at the link rate
  initial begin
    forever #80 osc = ~osc;
  end
  // Link clock stands still while run bit 1 is clear
  assign link_clk_out = osc & run_in[1];
  // Sync changes on the falling edge, clear of the sampling edge
  always_ff @(negedge osc) begin
    fs_r <= fs_level_in;
  end
  // Wire levels: the device's drive wins where it enables the pad
  assign wire_out.tx_clk = dev_pins_in.tx_clk_oe ? dev_pins_in.tx_clk_o : (osc & run_in[0]);
  assign wire_out.rx_clk = dev_pins_in.rx_clk_oe ? dev_pins_in.rx_clk_o : link_clk_out;
  assign wire_out.ext_clk = run_in[2] ? osc : ext_level_in;
  assign wire_out.rx_data = rxd_level_in;
  assign wire_out.rx_fs = dev_pins_in.rx_fs_oe ? dev_pins_in.rx_fs_o : fs_r;
endmodule

// *** sppc_ctl_test.sv ***
`timescale 1ns/1ns
`include "sppc_defs.svh"
module sppc_ctl_test;
  import sppc_pkg::*;
  // Design ports
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic link_clk;
  sppc_bus_t bus = '0;
  logic [15:0] rdata;
  sppc_pin_in_t pins_in;
  sppc_pin_out_t pins_out;
  // Partner controls
  logic [2:0] run = 3'h0;
  logic lvl_ext = 1'b0;
  logic lvl_rxd = 1'b0;
  logic fs_lvl = 1'b0;
  // Which clock pin the toggle counter watches
  logic obs_sel = 1'b0;
  wire obs = obs_sel ? pins_out.rx_clk_o : pins_out.tx_clk_o;
  // Bookkeeping
  int n_mismatch = 0;
  int comparisons = 0;
  logic [15:0] v;
  logic [15:0] base;
  int n;
  logic ok;
  // Direction table: pin control, control one, expected tx/rx clock enables
  logic [15:0] dir_pc [6] = '{16'h0300, 16'h0200, 16'h0000, 16'h0100, 16'h0100, 16'h0300};
  logic [15:0] dir_sc [6] = '{16'h0003, 16'h0003, 16'h0007, 16'h0007, 16'h000b, 16'h000b};
  logic [1:0] dir_oe [6] = '{2'h3, 2'h2, 2'h0, 2'h1, 2'h0, 2'h2};
  // System clock
  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  sppc_ctl dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .link_clk_in(link_clk),
    .bus_in(bus), .rdata_out(rdata), .pins_in(pins_in), .pins_out(pins_out));
  sppc_partner peer (.dev_pins_in(pins_out), .run_in(run), .ext_level_in(lvl_ext),
    .rxd_level_in(lvl_rxd), .fs_level_in(fs_lvl), .wire_out(pins_in), .link_clk_out(link_clk));
  // Register write, one strobe cycle
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge sys_clk_in);
    bus.wr <= 1'b0;
  endtask
  // Register read, data taken in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge sys_clk_in);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge sys_clk_in);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    cmp(d, exp);
  endtask
  // Pin synchronisers plus output register need a few cycles
  task automatic settle();
    repeat (8) @(posedge sys_clk_in);
    #1;
  endtask
  // Toggles of the watched clock pin over 64 cycles
  task automatic toggles(output int t);
    logic last;
    t = 0;
    settle();
    last = obs;
    repeat (64) begin
      @(posedge sys_clk_in);
      #1;
      if (obs !== last) t++;
      last = obs;
    end
  endtask
  // Spacing of two rises of the receive sync pin
  task automatic fs_gap(output int g);
    int first;
    logic prev;
    first = -1;
    g = 0;
    prev = 1'b1;
    for (int i = 0; i < 20000 && g == 0; i++) begin
      @(posedge sys_clk_in);
      #1;
      if (prev === 1'b0 && pins_out.rx_fs_o === 1'b1) begin
        if (first >= 0) g = i - first;
        else first = i;
      end
      prev = pins_out.rx_fs_o;
    end
  endtask
  // Single place where the run ends
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog, well beyond the expected run length
  initial begin
    #400_000;
    n_mismatch++;
    conclude();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    // Reset values and the unmapped place
    for (int a = 0; a < 5; a++) begin
      if (a != 3) rdchk(3'(a), 16'h0000);
    end
    // Write masks and field layout
    wr(`SPPC_A_SRG, 16'hffff);
    rdchk(`SPPC_A_SRG, 16'hffff);
    wr(3'h4, 16'hffff);
    rdchk(3'h4, 16'h0000);
    wr(`SPPC_A_SPC, 16'hffff);
    rdchk(`SPPC_A_SPC, 16'h001f);
    // Both sides out of reset: status bits stay 0 despite general I/O
    wr(`SPPC_A_PIN, 16'hffff);
    rdchk(`SPPC_A_PIN, 16'h3faf);
    // General I/O with both sides held in reset
    wr(`SPPC_A_SPC, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      lvl_ext <= k[0];
      lvl_rxd <= k[1];
      wr(`SPPC_A_PIN, 16'h3000 | (16'(k & 1) << 5));
      settle();
      rdchk(`SPPC_A_PIN, 16'h3000 | (16'(k & 1) * 16'h0060) | (16'(k >> 1) << 4));
      cmp(16'({pins_out.tx_data_oe, pins_out.tx_data_o}), 16'(2 | (k & 1)));
    end
    // Receiver out of reset hides the input levels
    wr(`SPPC_A_SPC, 16'h0002);
    rdchk(`SPPC_A_PIN, 16'h3020);
    // Clock pin directions
    wr(`SPPC_A_SRG, 16'h2000);
    for (int i = 0; i < 6; i++) begin
      wr(`SPPC_A_PIN, dir_pc[i]);
      wr(`SPPC_A_SPC, dir_sc[i]);
      settle();
      cmp(16'({pins_out.tx_clk_oe, pins_out.rx_clk_oe}), 16'(dir_oe[i]));
    end
    // Loop-back with pin output carries the partner's transmit clock
    wr(`SPPC_A_PIN, 16'h0100);
    wr(`SPPC_A_SPC, 16'h0007);
    @(posedge sys_clk_in);
    run <= 3'h1;
    obs_sel <= 1'b1;
    toggles(n);
    cmp(16'(n >= 5 && n <= 11), 16'h0001);
    // Generator reference: only the selected source moves the output
    wr(`SPPC_A_SPC, 16'h0003);
    for (int r = 0; r < 4; r++) begin
      wr(`SPPC_A_PIN, {6'h00, r != 3, r == 3, r[1], 7'h00});
      wr(`SPPC_A_SRG, {2'h0, r[0], 13'h0000});
      for (int s = 0; s < 3; s++) begin
        @(posedge sys_clk_in);
        run <= 3'(1 << s);
        obs_sel <= (r == 3);
        toggles(n);
        ok = (r == 0 && s == 2) || (r == 2 && s == 1) || (r == 3 && s == 0);
        ok = (r == 1) ? (n > 50) : (ok ? (n >= 5 && n <= 11) : (n == 0));
        cmp(16'(ok), 16'h0001);
      end
    end
    // Receive sync polarity: count on the leading edge only
    // Second reset with the link clock running, so the link side starts clean
    @(posedge sys_clk_in);
    resetn_in <= 1'b0;
    run <= 3'h2;
    repeat (60) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    wr(`SPPC_A_SRG, 16'h0000);
    for (int p = 0; p < 2; p++) begin
      wr(`SPPC_A_PIN, 16'(p) << 2);
      fs_lvl <= p[0];
      repeat (60) @(posedge sys_clk_in);
      rd(`SPPC_A_STAT, base);
      fs_lvl <= ~p[0];
      repeat (60) @(posedge sys_clk_in);
      rd(`SPPC_A_STAT, v);
      cmp(16'(v[7:0] - base[7:0]), 16'h0001);
      fs_lvl <= p[0];
      repeat (60) @(posedge sys_clk_in);
      rd(`SPPC_A_STAT, v);
      cmp(16'(v[7:0] - base[7:0]), 16'h0001);
    end
    // Single clock edges from the external reference, both polarities
    for (int q = 0; q < 2; q++) begin
      wr(`SPPC_A_PIN, 16'h0300 | (16'(q) * 16'h0003));
      lvl_ext <= 1'b0;
      lvl_rxd <= 1'b0;
      settle();
      rd(`SPPC_A_STAT, base);
      lvl_ext <= 1'b1;
      settle();
      rd(`SPPC_A_STAT, v);
      cmp(16'(4'(v[15:12] - base[15:12])), 16'(1 - q));
      lvl_rxd <= 1'b1;
      settle();
      lvl_ext <= 1'b0;
      settle();
      rd(`SPPC_A_STAT, v);
      cmp(16'(v[9]), 16'(1 - q));
    end
    // Frame period from the CPU reference, two system cycles per generator cycle
    @(posedge sys_clk_in);
    run <= 3'h0;
    wr(`SPPC_A_PIN, 16'h0400);
    for (int j = 0; j < 2; j++) begin
      wr(`SPPC_A_SRG, j ? 16'h2fff : 16'h2003);
      fs_gap(n);
      cmp(16'(n), j ? 16'h2000 : 16'h0008);
    end
    // Sync pin drive and idle level, transmit sync active low
    wr(`SPPC_A_PIN, 16'h0c08);
    settle();
    cmp(16'({pins_out.tx_fs_oe, pins_out.tx_fs_o, pins_out.rx_fs_oe}), 16'h0007);
    conclude();
  end
endmodule
